/* hub_mode_sequencer.sv */
// hub mode sequencer: standby, pass-through and hub stage control
`timescale 1ns/100ps
module hub_mode_sequencer
  import hub_seq_pkg::*;
#(
  parameter logic [19:0] INIT_CYCLES = 20'(INIT_CYC),
  parameter logic [15:0] CHG_LEN     = 16'(CHG_TICKS)
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        mode_reset_n,
  input  wire logic        passthru_sel_n,
  input  wire logic        reference_clock_in,
  input  wire logic [1:0]  serial_addr_select,
  input  wire logic [1:0]  ref_freq_select,
  input  wire logic        pll_locked,
  input  wire logic [1:0]  chg_result_in,
  input  wire logic        rom_chgdet_en,
  input  wire logic        int_clear,
  output logic [4:0]       stage,
  output logic             passthru_on,
  output logic             idle_switch_resistance,
  output logic             reg_main_en,
  output logic             reg_core_en,
  output logic             pll_run,
  output logic             core_pwr_en,
  output logic             core_rst_n,
  output logic             ds_port_en,
  output logic             rom_load,
  output logic             serial_port_en,
  output logic [1:0]       addr_latched,
  output logic [1:0]       freq_sel_latched,
  output logic [15:0]      ref_freq_khz,
  output logic             ref_clk_ok,
  output logic             chg_run,
  output logic             chg_abort,
  output logic [1:0]       chg_result,
  output logic             int_o,
  output logic             int_oe_n
);

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [7:0] pins_a;
  logic [7:0] pins_s;
  logic       m_rst_n;
  logic       m_byp_n;
  logic       ref_s;
  logic       lock_s;
  logic [1:0] addr_s;
  logic [1:0] fsel_s;
  logic [1:0] chg_s;

  assign pins_a = {mode_reset_n, passthru_sel_n, reference_clock_in,
                   pll_locked, serial_addr_select,
                   ref_freq_select};

  sync2 #(.W(8)) u_pin_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (pins_a),
    .q    (pins_s)
  );

  sync2 #(.W(2)) u_chg_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (chg_result_in),
    .q    (chg_s)
  );

  // charger results have their own synchroniser, apart from the straps
  assign m_rst_n = pins_s[7];
  assign m_byp_n = pins_s[6];
  assign ref_s   = pins_s[5];
  assign lock_s  = pins_s[4];
  assign addr_s  = pins_s[3:2];
  assign fsel_s  = pins_s[1:0];

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    stage_e      st;
    logic [19:0] init_cnt;
    logic [3:0]  ring_div;
    logic        ring_tick;
    logic [15:0] chg_cnt;
    logic        chg_run;
    logic        chg_tried;
    logic        chg_abort;
    logic [1:0]  chg_result;
    logic        int_pend;
    logic        rom_load;
    logic [1:0]  addr;
    logic [1:0]  fsel;
    logic [15:0] freq_khz;
    logic [7:0]  exp_edges;
    logic        passthru_on;
    logic        idle_sw;
    logic        reg_main_en;
    logic        reg_core_en;
    logic        pll_run;
    logic        core_pwr_en;
    logic        core_rst_n;
    logic        ds_port_en;
    logic        serial_en;
    logic        ref_ok;
  } seq_s;

  seq_s r;
  seq_s n;
  logic ref_ok_mon;
  logic clk_ready;
  logic hub_sel;
  logic chg_end;

  // ---------------------------------------------------------------------
  // reference activity monitor
  // ---------------------------------------------------------------------
  ref_activity_mon u_ref_mon (
    .clk       (clk),
    .rstn      (rstn),
    .ref_s     (ref_s),
    .ring_tick (r.ring_tick),
    .exp_edges (r.exp_edges),
    .ref_ok    (ref_ok_mon)
  );

  // a running reference alone is not enough: the PLL must also lock
  assign clk_ready = ref_ok_mon & lock_s;
  assign hub_sel   = m_rst_n & m_byp_n;
  assign chg_end   = r.chg_run && r.ring_tick &&
                     (r.chg_cnt == CHG_LEN - 16'h0001);

  // ---------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    n           = r;
    n.rom_load  = 1'b0;
    n.chg_abort = 1'b0;
    n.ref_ok    = ref_ok_mon;

    // ring oscillator stand-in: enable pulse from a divider on clk
    if (r.ring_div == RING_LAST) begin
      n.ring_div  = '0;
      n.ring_tick = 1'b1;
    end else begin
      n.ring_div  = r.ring_div + 4'h1;
      n.ring_tick = 1'b0;
    end

    // expected edge count held in standby and pass-through, taken from the select pins as they are latched in init
    case (r.st == ST_STANDBY || r.st == ST_BYPASS ? fsel_s : r.fsel)
      2'b00:   n.exp_edges = EDGES_00;
      2'b01:   n.exp_edges = EDGES_01;
      2'b10:   n.exp_edges = EDGES_10;
      default: n.exp_edges = EDGES_11;
    endcase

    // interrupt: a completion in the clearing cycle still wins
    if (int_clear) begin
      n.int_pend = 1'b0;
    end

    if (!m_rst_n) begin
      // reset pin low: drop everything except the ring divider and tick, expected edges and ref_ok
      n            = '0;
      n.st         = ST_STANDBY;
      n.ring_div   = r.ring_div;
      n.ring_tick  = r.ring_tick;
      n.exp_edges  = r.exp_edges;
      n.ref_ok     = ref_ok_mon;
    end else if (!m_byp_n) begin
      // pass-through: core powered down, settings lost
      n            = '0;
      n.st         = ST_BYPASS;
      n.ring_div   = r.ring_div;
      n.ring_tick  = r.ring_tick;
      n.exp_edges  = r.exp_edges;
      n.ref_ok     = ref_ok_mon;
    end else if (hub_sel) begin
      case (r.st)
        ST_STANDBY, ST_BYPASS: begin
          // hub selected: start initialization, latch straps, load ROM
          n.st       = ST_INIT;
          n.init_cnt = '0;
          n.rom_load = 1'b1;
          n.addr     = addr_s;
          n.fsel     = fsel_s;
        end
        ST_INIT: begin
          // fixed interval, then skip the wait if the clock is ready
          if (r.init_cnt == INIT_CYCLES - 20'h00001) begin
            n.st = clk_ready ? ST_CONFIG : ST_WAIT;
          end else begin
            n.init_cnt = r.init_cnt + 20'h00001;
          end
        end
        ST_WAIT: begin
          if (clk_ready) begin
            n.st = ST_CONFIG;
          end
          if (r.chg_run) begin
            if (lock_s) begin
              // lock during detection: abandon, keep no result
              n.chg_run   = 1'b0;
              n.chg_abort = 1'b1;
            end else if (chg_end) begin
              n.chg_run    = 1'b0;
              n.chg_result = chg_s;
              n.int_pend   = 1'b1;
            end else if (r.ring_tick) begin
              n.chg_cnt = r.chg_cnt + 16'h0001;
            end
          end else if (!ref_ok_mon && rom_chgdet_en && !r.chg_tried) begin
            // runs once per hub entry, timed by the ring ticks
            n.chg_run   = 1'b1;
            n.chg_tried = 1'b1;
            n.chg_cnt   = '0;
          end
        end
        ST_CONFIG: begin
          // later stages are handled elsewhere
          n.st = ST_CONFIG;
        end
        default: begin
          n.st = ST_STANDBY;
        end
      endcase
    end

    // a detection left running is stopped when the wait stage ends
    if (n.st != ST_WAIT && r.chg_run && n.chg_run) begin
      n.chg_run   = 1'b0;
      n.chg_abort = 1'b1;
    end

    // frequency decode of the latched select
    case (n.fsel)
      2'b00:   n.freq_khz = FREQ_KHZ_00;
      2'b01:   n.freq_khz = FREQ_KHZ_01;
      2'b10:   n.freq_khz = FREQ_KHZ_10;
      default: n.freq_khz = FREQ_KHZ_11;
    endcase

    // registered power, switch and port controls from the next stage
    n.passthru_on = (n.st == ST_BYPASS);
    n.idle_sw     = (n.st == ST_STANDBY);
    n.reg_main_en = (n.st != ST_STANDBY);
    n.reg_core_en = (n.st == ST_INIT) || (n.st == ST_WAIT) ||
                    (n.st == ST_CONFIG);
    n.pll_run     = n.reg_core_en;
    n.core_pwr_en = n.reg_core_en;
    // core held in reset during its first init cycle
    n.core_rst_n  = n.reg_core_en && !n.rom_load;
    n.ds_port_en  = (n.st == ST_CONFIG);
    n.serial_en   = (n.st == ST_CONFIG);
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r         <= '0;
      r.st      <= ST_STANDBY;
      r.idle_sw <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------------
  assign stage                  = r.st;
  assign passthru_on            = r.passthru_on;
  assign idle_switch_resistance = r.idle_sw;
  assign reg_main_en            = r.reg_main_en;
  assign reg_core_en            = r.reg_core_en;
  assign pll_run                = r.pll_run;
  assign core_pwr_en            = r.core_pwr_en;
  assign core_rst_n             = r.core_rst_n;
  assign ds_port_en             = r.ds_port_en;
  assign rom_load               = r.rom_load;
  assign serial_port_en         = r.serial_en;
  assign addr_latched           = r.addr;
  assign freq_sel_latched       = r.fsel;
  assign ref_freq_khz           = r.freq_khz;
  assign ref_clk_ok             = r.ref_ok;
  assign chg_run                = r.chg_run;
  assign chg_abort              = r.chg_abort;
  assign chg_result             = r.chg_result;
  // open drain: enable low pulls the line low while pending
  assign int_o                  = r.int_pend & 1'b0;
  assign int_oe_n               = ~r.int_pend;

endmodule : hub_mode_sequencer

/* hub_seq_pkg.sv */
// shared constants and types for the hub mode sequencer
package hub_seq_pkg;

  // ---------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ       = 200;          // core clock rate
  localparam int T_HUBINIT_US  = 3000;         // initialization stage, us
  localparam int INIT_CYC      = T_HUBINIT_US * CLK_MHZ;
  localparam int RING_DIV      = 8;            // clk cycles per ring tick
  localparam int T_WIN_NS      = 2000;         // activity window, ns
  localparam int WIN_TICKS     = (T_WIN_NS * CLK_MHZ) / (1000 * RING_DIV);
  localparam int T_CHGDET_US   = 1000;         // early detection length
  localparam int CHG_TICKS     = (T_CHGDET_US * CLK_MHZ) / RING_DIV;

  localparam logic [3:0] RING_LAST = 4'(RING_DIV - 1);
  localparam logic [7:0] WIN_LAST  = 8'(WIN_TICKS - 1);

  // ---------------------------------------------------------------------
  // reference frequency decode and expected edges per window
  // ---------------------------------------------------------------------
  localparam logic [15:0] FREQ_KHZ_00 = 16'h9600;  // 38400 kHz
  localparam logic [15:0] FREQ_KHZ_01 = 16'h6590;  // 26000 kHz
  localparam logic [15:0] FREQ_KHZ_10 = 16'h4b00;  // 19200 kHz
  localparam logic [15:0] FREQ_KHZ_11 = 16'h2ee0;  // 12000 kHz
  localparam logic [7:0]  EDGES_00    = 8'h4d;     // 77 per 2 us
  localparam logic [7:0]  EDGES_01    = 8'h34;     // 52
  localparam logic [7:0]  EDGES_10    = 8'h26;     // 38
  localparam logic [7:0]  EDGES_11    = 8'h18;     // 24
  localparam logic [7:0]  EDGE_TOL    = 8'h03;     // allowed deviation

  // ---------------------------------------------------------------------
  // operating modes and hub stages, one-hot
  // ---------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_STANDBY = 5'h01,
    ST_BYPASS  = 5'h02,
    ST_INIT    = 5'h04,
    ST_WAIT    = 5'h08,
    ST_CONFIG  = 5'h10
  } stage_e;

endpackage : hub_seq_pkg

/* sync2.sv */
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
module sync2
  import hub_seq_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s r;
  sync_s nxt;

  // first stage only feeds the second stage
  always_comb begin
    nxt    = r;
    nxt.s1 = d;
    nxt.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign q = r.s2;

endmodule : sync2

/* ref_activity_mon.sv */
// reference clock activity check: rising edges counted per ring window
`timescale 1ns/100ps
module ref_activity_mon
  import hub_seq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ref_s,      // synchronised reference level
  input  wire logic       ring_tick,  // ring oscillator enable pulse
  input  wire logic [7:0] exp_edges,  // expected edges per window
  output logic            ref_ok
);

  typedef struct packed {
    logic       prev;
    logic [7:0] edges;
    logic [7:0] ticks;
    logic       ok;
  } mon_s;

  mon_s r;
  mon_s nxt;
  logic rise;
  logic in_range;

  // only the positive edge of the reference is of interest
  assign rise     = ref_s & ~r.prev;
  assign in_range = (r.edges + EDGE_TOL >= exp_edges) &&
                    (r.edges <= exp_edges + EDGE_TOL);

  // window timed by the ring oscillator, so a dead reference reads zero
  always_comb begin
    nxt      = r;
    nxt.prev = ref_s;
    if (rise && r.edges != 8'hff) begin
      nxt.edges = r.edges + 8'h01;
    end
    if (ring_tick) begin
      if (r.ticks == WIN_LAST) begin
        nxt.ticks = '0;
        nxt.ok    = in_range;
        nxt.edges = {7'h00, rise};
      end else begin
        nxt.ticks = r.ticks + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign ref_ok = r.ok;

endmodule : ref_activity_mon

/* hub_mode_sequencer_sva.sv */
// port-level assertion checker for the hub mode sequencer
`timescale 1ns/100ps
module hub_mode_sequencer_sva
  import hub_seq_pkg::*;
#(
  parameter logic [19:0] INIT_CYCLES = 20'(INIT_CYC)
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       mode_reset_n,
  input wire logic [4:0] stage,
  input wire logic       passthru_on,
  input wire logic       idle_switch_resistance,
  input wire logic       reg_main_en,
  input wire logic       reg_core_en,
  input wire logic       pll_run,
  input wire logic       ds_port_en,
  input wire logic       rom_load,
  input wire logic       serial_port_en,
  input wire logic       ref_clk_ok,
  input wire logic       chg_run,
  input wire logic       chg_abort,
  input wire logic [1:0] chg_result,
  input wire logic       int_o,
  input wire logic       int_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // -------------------------------------------------------------
  // helper: consecutive cycles seen in the init stage
  // -------------------------------------------------------------
  logic [19:0] init_cnt_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_cnt_r <= 20'h0;
    end else begin
      init_cnt_r <= (stage == ST_INIT) ? init_cnt_r + 20'h1 : 20'h0;
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  chk_standby_power: assert property (stage == ST_STANDBY |->
    !reg_main_en && !pll_run && !ds_port_en && idle_switch_resistance)
    else $error("standby outputs wrong");
  chk_bypass_path: assert property (stage == ST_BYPASS |->
    passthru_on && !reg_core_en && !pll_run)
    else $error("bypass outputs wrong");
  chk_hub_switch_off: assert property (stage inside {ST_INIT, ST_WAIT,
    ST_CONFIG} |-> !passthru_on && reg_core_en)
    else $error("hub stage switch or regulator wrong");
  chk_reset_entry: assert property ($fell(mode_reset_n) |->
    ##[2:4] stage == ST_STANDBY)
    else $error("mode reset did not reach standby");
  chk_serial_gate: assert property (serial_port_en || ds_port_en |->
    stage == ST_CONFIG)
    else $error("serial port or ports enabled too early");
  chk_rom_pulse: assert property (rom_load |->
    stage == ST_INIT ##1 !rom_load)
    else $error("rom load pulse wrong");
  chk_init_bound: assert property (stage == ST_INIT |->
    init_cnt_r < INIT_CYCLES)
    else $error("init stage overran");
  chk_init_exit: assert property ($past(stage) == ST_INIT &&
    stage inside {ST_WAIT, ST_CONFIG} |-> init_cnt_r == INIT_CYCLES)
    else $error("init stage length wrong");
  chk_wait_exit: assert property ($past(stage) == ST_WAIT &&
    stage == ST_CONFIG |-> ref_clk_ok || $past(ref_clk_ok))
    else $error("left wait stage without valid reference");
  chk_abort_pulse: assert property (chg_abort |->
    !chg_run && $past(chg_run) ##1 !chg_abort)
    else $error("abort pulse wrong");
  chk_abort_keep: assert property (chg_abort && stage == ST_WAIT |->
    $stable(chg_result))
    else $error("abort captured results");
  chk_int_cause: assert property ($fell(int_oe_n) |->
    !chg_run && $past(chg_run) && !int_o)
    else $error("interrupt without completed detection");

  cover property (stage == ST_BYPASS);
  cover property ($past(stage) == ST_WAIT && stage == ST_CONFIG);
  cover property (chg_abort);
  cover property ($fell(int_oe_n));
endmodule : hub_mode_sequencer_sva

bind hub_mode_sequencer hub_mode_sequencer_sva #(
  .INIT_CYCLES(INIT_CYCLES)
) u_sva (
  .clk, .rstn, .mode_reset_n, .stage, .passthru_on,
  .idle_switch_resistance, .reg_main_en, .reg_core_en, .pll_run,
  .ds_port_en, .rom_load, .serial_port_en, .ref_clk_ok, .chg_run,
  .chg_abort, .chg_result, .int_o, .int_oe_n);

/* host_ctrl_model.sv */
// system controller and pll model driving the sequencer's pins
`timescale 1ns/100ps
module host_ctrl_model #(
  parameter int RST_MIN = 20000  // reset low cycles, 100 us at 200 MHz
) (
  input  wire logic clk,
  input  wire logic ref_en,
  input  wire logic lock_en,
  input  wire logic pll_run,
  output logic      mode_reset_n,
  output logic      passthru_sel_n,
  output logic      reference_clock_in,
  output logic      pll_locked
);
  logic osc = 1'h0;

  // 12 MHz reference for select 11; stands low while absent
  always #41.7 osc = ~osc;
  assign reference_clock_in = ref_en & osc;
  // a pll cannot lock while the device holds it stopped
  assign pll_locked = lock_en & pll_run;

  initial begin
    mode_reset_n = 1'h0;
    passthru_sel_n = 1'h0;
  end

  // -------------------------------------------------------------
  // mode pin sequences, changed just after a rising edge
  // -------------------------------------------------------------
  task automatic go_standby;
    @(posedge clk);
    mode_reset_n <= 1'h0;
    passthru_sel_n <= 1'h0;
    repeat (RST_MIN) @(posedge clk);
  endtask : go_standby

  task automatic go_hub;
    go_standby();
    mode_reset_n <= 1'h1;
    passthru_sel_n <= 1'h1;
  endtask : go_hub

  // reset pulsed and released before select goes low
  task automatic go_bypass;
    go_hub();
    @(posedge clk);
    passthru_sel_n <= 1'h0;
  endtask : go_bypass
endmodule : host_ctrl_model

/* test_hub_mode_sequencer.sv */
// self-checking bench for the hub mode sequencer
`timescale 1ns/100ps
module test_hub_mode_sequencer
  import hub_seq_pkg::*;
;
  // -------------------------------------------------------------
  // signals and instances
  // -------------------------------------------------------------
  localparam int INIT_N = 1000;  // short init stage keeps the run brief
  logic        clk = 1'h0, rstn = 1'h0, ref_en = 1'h0, lock_en = 1'h0;
  logic        rom_chgdet_en = 1'h0, int_clear = 1'h0;
  logic [1:0]  serial_addr_select = 2'h0, ref_freq_select = 2'h0;
  logic [1:0]  chg_result_in = 2'h0, addr_latched, freq_sel_latched;
  logic [1:0]  chg_result;
  logic [4:0]  stage;
  logic [15:0] ref_freq_khz;
  logic        mode_reset_n, passthru_sel_n, reference_clock_in;
  logic        pll_locked, passthru_on, idle_switch_resistance;
  logic        reg_main_en, reg_core_en, pll_run, core_pwr_en, core_rst_n;
  logic        ds_port_en, rom_load, serial_port_en, ref_clk_ok;
  logic        chg_run, chg_abort, int_o, int_oe_n;
  int          err_count = 0, samples_checked = 0;
  logic [15:0] khz_tab [4] = '{16'h9600, 16'h6590, 16'h4b00, 16'h2ee0};

  hub_mode_sequencer #(.INIT_CYCLES(20'(INIT_N)), .CHG_LEN(16'h0028))
  u_hub_mode_sequencer (
    .clk, .rstn, .mode_reset_n, .passthru_sel_n, .reference_clock_in,
    .serial_addr_select, .ref_freq_select, .pll_locked, .chg_result_in,
    .rom_chgdet_en, .int_clear, .stage, .passthru_on,
    .idle_switch_resistance, .reg_main_en, .reg_core_en, .pll_run,
    .core_pwr_en, .core_rst_n, .ds_port_en, .rom_load, .serial_port_en,
    .addr_latched, .freq_sel_latched, .ref_freq_khz, .ref_clk_ok,
    .chg_run, .chg_abort, .chg_result, .int_o, .int_oe_n);

  host_ctrl_model #(.RST_MIN(20)) u_host_ctrl_model (
    .clk, .ref_en, .lock_en, .pll_run, .mode_reset_n, .passthru_sel_n,
    .reference_clock_in, .pll_locked);

  always #2.5 clk = ~clk;

  // -------------------------------------------------------------
  // compare, wait and closing tasks
  // -------------------------------------------------------------
  task automatic cb(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : cb

  task automatic cv(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : cv

  // bounded poll for a stage, then compare it
  task automatic wait_stage(input logic [4:0] s, input int n);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (stage !== s && i < n);
    cv(16'(stage), 16'(s));
  endtask : wait_stage

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_standby;
    u_host_ctrl_model.go_standby();
    #1;
    cv(16'(stage), 16'(ST_STANDBY));
    cb(reg_main_en, 1'h0);
    cb(pll_run, 1'h0);
    cb(ds_port_en, 1'h0);
    cb(idle_switch_resistance, 1'h1);
    cv(16'(addr_latched), 16'h0);
  endtask : t_standby

  task automatic t_bypass;
    u_host_ctrl_model.go_bypass();
    wait_stage(ST_BYPASS, 30);
    cb(passthru_on, 1'h1);
    cb(core_pwr_en, 1'h0);
  endtask : t_bypass

  // every select code, straps moved after the latch point
  task automatic t_init_decode;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ref_freq_select <= 2'(i);
      serial_addr_select <= 2'(3 - i);
      u_host_ctrl_model.go_hub();
      wait_stage(ST_INIT, 30);
      cb(rom_load, 1'h1);
      cb(serial_port_en, 1'h0);
      cb(core_rst_n, 1'h0);
      @(posedge clk);
      ref_freq_select <= 2'(3 - i);
      serial_addr_select <= 2'(i);
      repeat (5) @(posedge clk);
      #1;
      cv(16'(freq_sel_latched), 16'(i));
      cv(16'(addr_latched), 16'(3 - i));
      cv(ref_freq_khz, khz_tab[i]);
      cb(core_rst_n, 1'h1);
      cb(reg_core_en, 1'h1);
    end
  endtask : t_init_decode

  // reference running before entry: wait stage is skipped
  task automatic t_hub_config;
    int n;
    n = 0;
    @(posedge clk);
    // select 11 matches the model's 12 MHz reference
    ref_freq_select <= 2'h3;
    ref_en <= 1'h1;
    lock_en <= 1'h1;
    u_host_ctrl_model.go_hub();
    wait_stage(ST_INIT, 30);
    while (stage === ST_INIT && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    cv(16'(n), 16'(INIT_N));
    cv(16'(stage), 16'(ST_CONFIG));
    cb(passthru_on, 1'h0);
    cb(serial_port_en, 1'h1);
  endtask : t_hub_config

  task automatic t_chg_done;
    int i;
    i = 0;
    @(posedge clk);
    ref_en <= 1'h0;
    lock_en <= 1'h0;
    rom_chgdet_en <= 1'h1;
    chg_result_in <= 2'h2;
    u_host_ctrl_model.go_hub();
    wait_stage(ST_WAIT, 1100);
    repeat (3) @(posedge clk);
    #1;
    cb(chg_run, 1'h1);
    cb(serial_port_en, 1'h0);
    while (chg_run === 1'h1 && i < 600) begin
      @(posedge clk);
      #1;
      i++;
    end
    cv(16'(chg_result), 16'h0002);
    cb(int_oe_n, 1'h0);
    @(posedge clk);
    int_clear <= 1'h1;
    @(posedge clk);
    int_clear <= 1'h0;
    ref_en <= 1'h1;
    lock_en <= 1'h1;
    #1;
    cb(int_oe_n, 1'h1);
    wait_stage(ST_CONFIG, 1200);
  endtask : t_chg_done

  // lock arrives mid-detection without a valid reference
  task automatic t_chg_abort;
    int i;
    i = 0;
    ref_en <= 1'h0;
    lock_en <= 1'h0;
    u_host_ctrl_model.go_hub();
    wait_stage(ST_WAIT, 1100);
    lock_en <= 1'h1;
    while (chg_abort !== 1'h1 && i < 20) begin
      @(posedge clk);
      #1;
      i++;
    end
    cb(chg_abort, 1'h1);
    @(posedge clk);
    #1;
    cb(chg_abort, 1'h0);
    cv(16'(chg_result), 16'h0);
    cb(int_oe_n, 1'h1);
    cv(16'(stage), 16'(ST_WAIT));
  endtask : t_chg_abort

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    t_standby();
    t_bypass();
    t_init_decode();
    t_hub_config();
    t_standby();
    t_chg_done();
    t_chg_abort();
    test_done();
  end

  // watchdog sized well past the longest expected run
  initial begin
    #200000;
    err_count++;
    test_done();
  end
endmodule : test_hub_mode_sequencer
